// ==== dv/act_conv_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// behavioural converter cores: each finishes a fixed time after its start pulse
module act_conv_model
  import act_pkg::*;
#(
  parameter int unsigned NUM_CONV = 2
) (
  input  wire logic                      clock,       // system clock
  input  wire logic                      reset,       // synchronous, active high
  input  wire logic [NUM_CONV-1:0]       conv_start,  // start pulses
  output logic      [NUM_CONV-1:0]       conv_done,   // result valid pulses
  output logic      [RES_W*NUM_CONV-1:0] conv_result  // packed results
);
  for (genvar i = 0; i < NUM_CONV; i++) begin : g_conv
    localparam logic [9:0] VAL = (i % 2 == 1) ? 10'h1CA : 10'h2B5;
    logic [7:0] cnt_q;
    logic       busy_q;
    logic       done_q;
    // converter 1 is much slower, so the group must wait for the last one
    always_ff @(posedge clock) begin
      if (reset) begin
        busy_q <= 1'b0;
        cnt_q  <= 8'h00;
        done_q <= 1'b0;
      end else begin
        done_q <= 1'b0;
        if (conv_start[i]) begin
          busy_q <= 1'b1;
          cnt_q  <= 8'(6 + 30 * i);
        end else if (busy_q && cnt_q == 8'h00) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else if (busy_q) begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
    // outside the done pulse the result lines carry garbage, not the last value
    assign conv_done[i] = done_q;
    assign conv_result[RES_W*i +: RES_W] = done_q ? VAL : ~VAL;
  end
endmodule // act_conv_model
`default_nettype wire

// ==== dv/test_act_common_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the converter common control and trigger block
module test_act_common_ctrl;
  import act_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  converter_enable = 2'h3;
  logic [1:0]  conv_done;
  logic [19:0] conv_result;
  logic [3:0]  src = 4'h0;  // timer0, timer1, timer2, external pin
  logic        rc_clk = 1'b0;
  logic [1:0]  conv_start;
  logic [2:0]  conv_clock_sel;
  logic [1:0]  pos_ref_sel;
  logic        vref_ext_sel;
  logic        irq;
  logic        clk_en;
  logic [7:0]  rd;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n_st0 = 0;
  int          n_st1 = 0;

  act_common_ctrl #(.NUM_CONV(2)) DUT (
    .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .converter_enable(converter_enable), .conv_done(conv_done), .conv_result(conv_result),
    .timer0_ovf(src[0]), .timer1_ovf(src[1]), .timer2_match(src[2]),
    .ext_trigger_pin(src[3]), .internal_rc_clock(rc_clk), .conv_start(conv_start),
    .conv_clk_en(clk_en), .conv_clock_sel(conv_clock_sel), .pos_ref_sel(pos_ref_sel),
    .vref_ext_sel(vref_ext_sel), .irq(irq));

  act_conv_model #(.NUM_CONV(2)) u_conv (
    .clock(clock), .reset(reset), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result));

  always #50 clock = ~clock;

  // counts launches per converter, makes a slow rc clock and cuts a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    rc_clk <= cycles[2];
    if (!reset && conv_start[0] === 1'b1) n_st0 <= n_st0 + 1;
    if (!reset && conv_start[1] === 1'b1) n_st1 <= n_st1 + 1;
    if (cycles == 30000) begin
      n_fail = n_fail + 1;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // bus cycles hold the request until waitrequest is sampled low
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic rdr(input logic [5:0] a);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    if (avs_readdata[31:8] !== 24'h00_0000) begin
      n_fail++;
      $display("BAD %0t upper read bits set", $time);
    end
    avs_read <= 1'b0;
  endtask

  // polls the group busy bit until the launched group has finished
  task automatic wait_idle;
    rdr(OFS_COMMON);
    while (rd[GO_POS] === 1'b1) rdr(OFS_COMMON);
  endtask

  task automatic t_reset;
    rdr(OFS_COMMON);
    chk(rd, 8'h00);
    rdr(OFS_TRIGGER);
    chk(rd, 8'h00);
    rdr(6'h3C);
    chk(rd, 8'h00);
    wr(OFS_COMMON, 8'hFB);
    rdr(OFS_COMMON);
    chk(rd, 8'hF3);
    wr(OFS_TRIGGER, 8'h8F);
    rdr(OFS_TRIGGER);
    chk(rd, 8'h00);
    avs_byteenable <= 4'hE;
    wr(OFS_COMMON, 8'h00);
    avs_byteenable <= 4'hF;
    rdr(OFS_COMMON);
    chk(rd, 8'hF3);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdr(OFS_COMMON);
    chk(rd, 8'h00);
  endtask

  // enable pulses are counted over a window that every ratio divides;
  // the rc codes follow the bench rc clock, one rising edge per 8 cycles
  task automatic t_codes;
    int n;
    int ratio [8] = '{2, 8, 32, 8, 4, 16, 64, 8};
    for (int k = 0; k < 8; k++) begin
      wr(OFS_COMMON, {1'b0, 3'(k), 4'h0});
      repeat (2) @(posedge clock);
      chk({5'h0, conv_clock_sel}, 8'(k));
      n = 0;
      repeat (128) begin
        @(posedge clock);
        if (clk_en === 1'b1) n++;
      end
      chk(8'(n), 8'(128 / ratio[k]));
    end
    for (int r = 0; r < 4; r++) begin
      wr(OFS_COMMON, 8'(r));
      repeat (2) @(posedge clock);
      chk({6'h0, pos_ref_sel}, 8'(r));
      chk({7'h0, vref_ext_sel}, {7'h0, r == 2});
    end
  endtask

  // a go write launches the enabled converters; results land in the chosen layout
  task automatic t_go(input logic just, input logic [1:0] en);
    int s0;
    int s1;
    s0 = n_st0;
    s1 = n_st1;
    converter_enable <= en;
    wr(OFS_COMMON, {just, 7'h04});
    rdr(OFS_COMMON);
    chk(rd, {just, 7'h04});
    repeat (15) @(posedge clock);
    rdr(OFS_COMMON);
    chk(rd, {just, 4'h0, en[1], 2'h0});
    rdr(OFS_BUSY);
    chk(rd, {6'h0, en[1], 1'b0});
    wait_idle;
    chk(8'(n_st0 - s0), {7'h0, en[0]});
    chk(8'(n_st1 - s1), {7'h0, en[1]});
    rdr(OFS_RESULT_BASE);
    chk(rd, just ? 8'h02 : 8'hAD);
    rdr(6'h24);
    chk(rd, just ? 8'hB5 : 8'h40);
    if (en[1]) begin
      rdr(6'h28);
      chk(rd, just ? 8'h01 : 8'h72);
      rdr(6'h2C);
      chk(rd, just ? 8'hCA : 8'h80);
    end
  endtask

  task automatic t_irq;
    converter_enable <= 2'h3;
    wr(OFS_IRQ_MASK, 8'h00);
    wr(OFS_IRQ_STATUS, 8'h03);
    wr(OFS_COMMON, 8'h04);
    wait_idle;
    rdr(OFS_IRQ_STATUS);
    chk(rd, 8'h01);
    repeat (2) @(posedge clock);
    chk({7'h0, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clock);
    chk({7'h0, irq}, 8'h01);
    wr(OFS_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clock);
    chk({7'h0, irq}, 8'h00);
  endtask

  // every trigger code against every source; only the selected one launches
  task automatic t_trig;
    int  b;
    logic hit;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_TRIGGER, {1'b0, 3'(c), 4'h0});
      for (int s = 0; s < 4; s++) begin
        wr(OFS_IRQ_STATUS, 8'h03);
        b = n_st0;
        hit = (c == 3 && s == 0) || (c == 4 && s == 1) || (c == 5 && s == 2) || (c > 5 && s == 3);
        @(posedge clock);
        src[s] <= 1'b1;
        repeat (s == 3 ? 4 : 1) @(posedge clock);
        src[s] <= 1'b0;
        repeat (6) @(posedge clock);
        wait_idle;
        chk(8'(n_st0 - b), {7'h0, hit});
        rdr(OFS_IRQ_STATUS);
        chk(rd, {6'h0, hit, hit});
      end
    end
  endtask

  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_codes;
    t_go(1'b0, 2'h3);
    t_go(1'b1, 2'h3);
    t_go(1'b1, 2'h1);
    t_irq;
    t_trig;
    stop_test;
  end
endmodule // test_act_common_ctrl
`default_nettype wire

// ==== include/act_pkg.sv ====
`default_nettype none
// shared constants of the converter common control and trigger block
package act_pkg;
  // register byte offsets on the avalon slave
  localparam logic [5:0] OFS_COMMON      = 6'h00;
  localparam logic [5:0] OFS_TRIGGER     = 6'h04;
  localparam logic [5:0] OFS_IRQ_STATUS  = 6'h08;
  localparam logic [5:0] OFS_IRQ_MASK    = 6'h0C;
  localparam logic [5:0] OFS_BUSY        = 6'h10;
  localparam logic [5:0] OFS_RESULT_BASE = 6'h20;  // 8 bytes per converter, high then low

  // common control field positions
  localparam int unsigned JUSTIFY_POS = 7;
  localparam int unsigned CLKSEL_LSB  = 4;
  localparam int unsigned GO_POS      = 2;
  localparam int unsigned PREF_LSB    = 0;
  // trigger control field position
  localparam int unsigned TRIG_LSB    = 4;

  // writable bits and reset values
  localparam logic [7:0] COMMON_WMASK  = 8'hF3;
  localparam logic [7:0] TRIGGER_WMASK = 8'h70;
  localparam logic [7:0] COMMON_RESET  = 8'h00;
  localparam logic [7:0] TRIGGER_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;

  // conversion clock codes
  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_RC    = 3'h3;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [2:0] CLK_RC_B  = 3'h7;

  // divider terminal counts (ratio minus one)
  localparam logic [5:0] DIV2_LAST  = 6'h01;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV8_LAST  = 6'h07;
  localparam logic [5:0] DIV16_LAST = 6'h0F;
  localparam logic [5:0] DIV32_LAST = 6'h1F;
  localparam logic [5:0] DIV64_LAST = 6'h3F;

  // positive reference codes
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_RSVD   = 2'h1;
  localparam logic [1:0] PREF_EXT    = 2'h2;

  // auto trigger codes
  localparam logic [2:0] TRIG_NONE  = 3'h0;
  localparam logic [2:0] TRIG_RSVD1 = 3'h1;
  localparam logic [2:0] TRIG_RSVD2 = 3'h2;
  localparam logic [2:0] TRIG_T0    = 3'h3;
  localparam logic [2:0] TRIG_T1    = 3'h4;
  localparam logic [2:0] TRIG_T2    = 3'h5;
  localparam logic [2:0] TRIG_EXT_A = 3'h6;
  localparam logic [2:0] TRIG_EXT_B = 3'h7;

  // interrupt status bits
  localparam int unsigned IRQ_DONE_POS = 0;
  localparam int unsigned IRQ_TRIG_POS = 1;

  localparam int unsigned RES_W = 10;

  // group conversion sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } act_grp_state_t;
endpackage : act_pkg
`default_nettype wire

// ==== rtl/act_common_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// How it works
// - left justified puts bits 9..2 high, bits 1..0 atop the low byte.
// - clock field picks an oscillator division or the internal rc clock, codes 011 and 111.
// - writing go starts all enabled converters together; go reads one while busy.
// - reference code 00 selects supply, 10 external pin, 01 is reserved.
// - trigger 000 none, 001 and 010 reserved, 011 timer0, 100 timer1 overflow.
// - trigger code 101 starts conversions on each timer2 period match that arrives while idle.
// - trigger codes 110 and 111 start conversions on external pin rising edges.
// - timer events still set their own flags while also starting conversions.
module act_common_ctrl
  import act_pkg::*;
#(
  parameter int unsigned NUM_CONV = 2
) (
  input  wire logic                  clock,              // system clock, 10 MHz
  input  wire logic                  reset,              // synchronous, active high
  input  wire logic [5:0]            avs_address,        // byte address
  input  wire logic                  avs_read,           // read request
  input  wire logic                  avs_write,          // write request
  input  wire logic [31:0]           avs_writedata,      // write data
  input  wire logic [3:0]            avs_byteenable,     // lane 0 carries the registers
  output logic      [31:0]           avs_readdata,       // read data
  output logic                       avs_waitrequest,    // stall until answer
  input  wire logic [NUM_CONV-1:0]   converter_enable,   // per converter module enable
  input  wire logic [NUM_CONV-1:0]   conv_done,          // result valid pulses
  input  wire logic [RES_W*NUM_CONV-1:0] conv_result,    // packed raw results
  input  wire logic                  timer0_ovf,         // timer0 overflow pulse
  input  wire logic                  timer1_ovf,         // timer1 overflow pulse
  input  wire logic                  timer2_match,       // timer2 period match pulse
  input  wire logic                  ext_trigger_pin,    // asynchronous trigger pin
  input  wire logic                  internal_rc_clock,  // asynchronous rc clock
  output logic      [NUM_CONV-1:0]   conv_start,         // one-cycle start pulses
  output logic                       conv_clk_en,        // conversion clock enable pulse
  output logic      [2:0]            conv_clock_sel,     // selected clock code
  output logic      [1:0]            pos_ref_sel,        // positive reference code
  output logic                       vref_ext_sel,       // reference from external pin
  output logic                       irq                 // level interrupt
);
  // results are decoded from two address bits, so four converters at most
  if (NUM_CONV < 1 || NUM_CONV > 4) begin : g_bad_num
    $error("NUM_CONV must be 1 to 4");
  end

  // address match used across the decoder
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
    hit = (addr[5:2] == ofs[5:2]);
  endfunction

  // divider terminal count for a clock code
  function automatic logic [5:0] div_last(input logic [2:0] code);
    case (code)
      CLK_DIV2:  div_last = DIV2_LAST;
      CLK_DIV4:  div_last = DIV4_LAST;
      CLK_DIV8:  div_last = DIV8_LAST;
      CLK_DIV16: div_last = DIV16_LAST;
      CLK_DIV32: div_last = DIV32_LAST;
      CLK_DIV64: div_last = DIV64_LAST;
      default:   div_last = DIV2_LAST;
    endcase
  endfunction

  logic [7:0]          common_q;
  logic [7:0]          trigger_q;
  logic [1:0]          status_q;
  logic [1:0]          status_d;
  logic [1:0]          mask_q;
  logic                waitreq_q;
  logic [31:0]         rdata_q;
  logic                irq_q;
  act_grp_state_t      state_q;
  logic [NUM_CONV-1:0] pending_q;
  logic [NUM_CONV-1:0] start_q;
  logic [5:0]          div_cnt_q;
  logic                clk_en_q;
  logic [2:0]          sync_q [0:1];
  logic [1:0]          level_q;
  logic [1:0]          rise;
  logic [1:0]          pins;
  logic [7:0]          res_hi [0:3];
  logic [7:0]          res_lo [0:3];

  // bus handshake: requests are taken at the edge where waitrequest is low
  wire req      = avs_read | avs_write;
  wire accept   = req & ~waitreq_q;
  wire wr_acc   = accept & avs_write & avs_byteenable[0];
  wire [7:0] wb = avs_writedata[7:0];

  // field views
  wire       justify   = common_q[JUSTIFY_POS];
  wire [2:0] clk_code  = common_q[CLKSEL_LSB +: 3];
  wire [1:0] pref_code = common_q[PREF_LSB +: 2];
  wire [2:0] trig_code = trigger_q[TRIG_LSB +: 3];
  wire       busy      = (state_q == ST_WAIT);

  // register write strobes
  wire wr_common  = wr_acc & hit(avs_address, OFS_COMMON);
  wire wr_trigger = wr_acc & hit(avs_address, OFS_TRIGGER);
  wire wr_status  = wr_acc & hit(avs_address, OFS_IRQ_STATUS);
  wire wr_mask    = wr_acc & hit(avs_address, OFS_IRQ_MASK);
  wire go_write   = wr_common & wb[GO_POS];

  // pin synchronisers: three stages, a change counts once stages two and three agree
  assign pins = {internal_rc_clock, ext_trigger_pin};
  for (genvar p = 0; p < 2; p++) begin : g_sync
    always_ff @(posedge clock) begin
      if (reset) begin
        sync_q[p]  <= 3'h0;
        level_q[p] <= 1'b0;
      end else begin
        sync_q[p] <= {sync_q[p][1:0], pins[p]};
        if (sync_q[p][1] == sync_q[p][2]) begin
          level_q[p] <= sync_q[p][2];
        end
      end
    end
    assign rise[p] = (sync_q[p][1] == sync_q[p][2]) & sync_q[p][2] & ~level_q[p];
  end
  wire ext_rise = rise[0];
  wire rc_rise  = rise[1];

  // auto trigger selection; timer pulses are only observed, never consumed,
  // so the timers keep setting their own flags
  wire trig_ext  = (trig_code == TRIG_EXT_A) | (trig_code == TRIG_EXT_B);
  wire trig_fire = ((trig_code == TRIG_T0) & timer0_ovf)
                 | ((trig_code == TRIG_T1) & timer1_ovf)
                 | ((trig_code == TRIG_T2) & timer2_match)
                 | (trig_ext & ext_rise);
  // a new group starts only from idle; triggers while busy are dropped
  wire launch    = ~busy & (go_write | trig_fire);
  wire [NUM_CONV-1:0] still_pending = pending_q & ~conv_done;
  wire group_done = busy & ~(|still_pending);

  // group sequencer: go stays set until every launched converter has loaded
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      pending_q <= '0;
      start_q   <= '0;
    end else begin
      start_q <= '0;
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            start_q   <= converter_enable;
            pending_q <= converter_enable;
            state_q   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          pending_q <= still_pending;
          if (group_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q   <= ST_IDLE;
          pending_q <= '0;
        end
      endcase
    end
  end

  // control registers; go is not stored, it reads back the sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      common_q  <= COMMON_RESET;
      trigger_q <= TRIGGER_RESET;
      mask_q    <= IRQ_RESET;
    end else begin
      if (wr_common) begin
        common_q <= wb & COMMON_WMASK;
      end
      if (wr_trigger) begin
        trigger_q <= wb & TRIGGER_WMASK;
      end
      if (wr_mask) begin
        mask_q <= wb[1:0];
      end
    end
  end

  // conversion clock: divided enable or a tick per rc clock rising edge
  wire rc_sel   = (clk_code == CLK_RC) | (clk_code == CLK_RC_B);
  wire div_tick = (div_cnt_q >= div_last(clk_code));
  always_ff @(posedge clock) begin
    if (reset) begin
      div_cnt_q <= 6'h00;
      clk_en_q  <= 1'b0;
    end else begin
      div_cnt_q <= div_tick ? 6'h00 : div_cnt_q + 6'h01;
      clk_en_q  <= rc_sel ? rc_rise : div_tick;
    end
  end

  // sticky status; a new event in the cycle of its clear survives
  assign status_d = (status_q & ~(wr_status ? wb[1:0] : 2'h0))
                  | {trig_fire, group_done};
  always_ff @(posedge clock) begin
    if (reset) begin
      status_q <= IRQ_RESET;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= |(status_q & mask_q);
    end
  end

  // result byte pairs, unused slots read zero
  for (genvar i = 0; i < 4; i++) begin : g_res
    if (i < NUM_CONV) begin : g_on
      act_result_fmt u_fmt (
        .clock      (clock),
        .reset      (reset),
        .load       (conv_done[i]),
        .right_just (justify),
        .result     (conv_result[i*RES_W +: RES_W]),
        .high_q     (res_hi[i]),
        .low_q      (res_lo[i])
      );
    end else begin : g_off
      assign res_hi[i] = 8'h00;
      assign res_lo[i] = 8'h00;
    end
  end

  // read decode; unimplemented bits and unmapped words read zero
  wire [7:0] common_rd = common_q | {5'h00, busy, 2'h0};
  wire       res_hit   = avs_address[5];
  wire [1:0] res_idx   = avs_address[4:3];
  wire [7:0] res_byte  = avs_address[2] ? res_lo[res_idx] : res_hi[res_idx];
  wire [NUM_CONV-1:0] busy_bits = pending_q;
  wire [7:0] rd_byte   =
      hit(avs_address, OFS_COMMON)     ? common_rd :
      hit(avs_address, OFS_TRIGGER)    ? trigger_q :
      hit(avs_address, OFS_IRQ_STATUS) ? {6'h00, status_q} :
      hit(avs_address, OFS_IRQ_MASK)   ? {6'h00, mask_q} :
      hit(avs_address, OFS_BUSY)       ? 8'(busy_bits) :
      res_hit                          ? res_byte : 8'h00;

  // one wait cycle per access gives a registered answer
  always_ff @(posedge clock) begin
    if (reset) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else if (accept) begin
      waitreq_q <= 1'b1;
    end else if (req) begin
      waitreq_q <= 1'b0;
      rdata_q   <= {24'h00_0000, rd_byte};
    end
  end

  // outputs straight from flops
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign conv_start      = start_q;
  assign conv_clk_en     = clk_en_q;
  assign irq             = irq_q;
  // reference select registered so the analog side sees a clean level
  logic [1:0] pref_q;
  logic       ext_ref_q;
  logic [2:0] clk_sel_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      pref_q    <= PREF_SUPPLY;
      ext_ref_q <= 1'b0;
      clk_sel_q <= CLK_DIV2;
    end else begin
      pref_q    <= pref_code;
      ext_ref_q <= (pref_code == PREF_EXT);  // 00, 01 and 11 keep the supply
      clk_sel_q <= clk_code;
    end
  end
  assign pos_ref_sel    = pref_q;
  assign vref_ext_sel   = ext_ref_q;
  assign conv_clock_sel = clk_sel_q;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_RIGHT_JUST: assert property (
    conv_done[0] & justify |=> res_hi[0] == {6'h00, $past(conv_result[9:8])}
  ) else $error("right justified high byte wrong");
  AST_LEFT_JUST: assert property (
    conv_done[0] & ~justify |=> res_hi[0] == $past(conv_result[9:2]) && res_lo[0][5:0] == 6'h00
  ) else $error("left justified layout wrong");
  AST_RC_TICK: assert property (
    rc_sel & rc_rise & ~wr_common |=> clk_en_q ##1 clk_sel_q == CLK_RC || clk_sel_q == CLK_RC_B
  ) else $error("rc clock tick not passed");
  AST_GO_LAUNCH: assert property (
    go_write & ~busy |=> start_q == $past(converter_enable) && busy && common_rd[GO_POS]
  ) else $error("go did not launch enabled converters");
  AST_EXT_REF: assert property (
    pref_code == PREF_RSVD |=> ~ext_ref_q
  ) else $error("reserved reference code chose external pin");
  AST_RESET_CLEAR: assert property (
    @(posedge clock) disable iff (1'b0)
    reset |=> common_q == 8'h00 && trigger_q == 8'h00 && ~busy
              && status_q == IRQ_RESET && mask_q == IRQ_RESET
  ) else $error("fields not cleared by reset");
  AST_NO_TRIGGER: assert property (
    trig_code <= TRIG_RSVD2 & ~go_write |=> start_q == '0
  ) else $error("conversion started without a trigger");
  AST_T2_MATCH: assert property (
    trig_code == TRIG_T2 & timer2_match & ~busy |=> busy ##0 start_q == $past(converter_enable)
  ) else $error("timer2 match did not start conversion");
  AST_EXT_EDGE: assert property (
    trig_ext & ext_rise & ~busy |=> busy
  ) else $error("external edge did not start conversion");
  AST_GO_HOLDS: assert property (
    busy & (|still_pending) |=> busy [*1] ##0 common_rd[GO_POS]
  ) else $error("go cleared before all results loaded");
  // triggers, group end, reference, clock enable and low result byte
  AST_TRIG_FLAG: assert property (
    trig_fire |=> status_q[IRQ_TRIG_POS]
  ) else $error("selected trigger did not set its flag");
  AST_T0_OVF: assert property (
    trig_code == TRIG_T0 & timer0_ovf & ~busy |=> busy
  ) else $error("timer0 overflow did not start conversion");
  AST_T1_OVF: assert property (
    trig_code == TRIG_T1 & timer1_ovf & ~busy |=> busy
  ) else $error("timer1 overflow did not start conversion");
  AST_GO_CLEAR: assert property (
    group_done |=> ~busy
  ) else $error("go stayed set after all results loaded");
  AST_DONE_FLAG: assert property (
    group_done |=> status_q[IRQ_DONE_POS]
  ) else $error("group end did not set its flag");
  AST_EXT_SEL: assert property (
    pref_code == PREF_EXT |=> ext_ref_q && pref_q == PREF_EXT
  ) else $error("external reference code not passed on");
  AST_DIV_PULSE: assert property (
    ~rc_sel & $past(~rc_sel) & clk_en_q |=> ~clk_en_q
  ) else $error("divided clock enable lasted two cycles");
  AST_RC_ONLY: assert property (
    rc_sel & ~rc_rise |=> ~clk_en_q
  ) else $error("rc clock enable without an rc edge");
  AST_LEFT_LOW: assert property (
    conv_done[0] & ~justify |=> res_lo[0][7:6] == $past(conv_result[1:0])
  ) else $error("left justified low bits wrong");
  AST_RIGHT_LOW: assert property (
    conv_done[0] & justify |=> res_lo[0] == $past(conv_result[7:0])
  ) else $error("right justified low byte wrong");
endmodule : act_common_ctrl
`default_nettype wire

// ==== rtl/act_result_fmt.sv ====
`timescale 1ns/100ps
`default_nettype none
// places one 10-bit result into its byte pair on load, unused bits zero
module act_result_fmt
  import act_pkg::*;
(
  input  wire logic             clock,       // system clock
  input  wire logic             reset,       // synchronous, active high
  input  wire logic             load,        // result valid pulse
  input  wire logic             right_just,  // 1 right, 0 left
  input  wire logic [RES_W-1:0] result,      // raw converter result
  output logic      [7:0]       high_q,      // high result byte
  output logic      [7:0]       low_q        // low result byte
);
  logic [7:0] high_d;
  logic [7:0] low_d;

  // both layouts pad with zeros so stale bits never leak out
  assign high_d = right_just ? {6'h00, result[9:8]} : result[9:2];
  assign low_d  = right_just ? result[7:0] : {result[1:0], 6'h00};

  // hold the pair until the next load
  always_ff @(posedge clock) begin
    if (reset) begin
      high_q <= 8'h00;
      low_q  <= 8'h00;
    end else if (load) begin
      high_q <= high_d;
      low_q  <= low_d;
    end
  end
endmodule : act_result_fmt
`default_nettype wire
